/* inc/hrs_regs.svh */
// register offsets, field positions, reset values and sizes of the return stack
`ifndef HRS_REGS_SVH
`define HRS_REGS_SVH

`define HRS_DEPTH              16
`define HRS_WIDTH              15
`define HRS_PTR_W              5
`define HRS_IDX_W              4
`define HRS_ADDR_W             12

`define HRS_PTR_EMPTY          5'h1f
`define HRS_PTR_TOP            5'h0f
`define HRS_PTR_BOTTOM         5'h00

`define HRS_OFF_TOS_LOW        12'h000
`define HRS_OFF_TOS_HIGH       12'h004
`define HRS_OFF_STACK_POINTER  12'h008
`define HRS_OFF_CTRL           12'h00c
`define HRS_OFF_STATUS         12'h010
`define HRS_OFF_MASK           12'h014

`define HRS_CTRL_FAULT_RST_BIT 0
`define HRS_STAT_OVF_BIT       0
`define HRS_STAT_UNF_BIT       1
`define HRS_STAT_W             2

`define HRS_CTRL_RESET         1'h0
`define HRS_STATUS_RESET       2'h0
`define HRS_MASK_RESET         2'h0
`define HRS_ENTRY_RESET        15'h0000

`endif

/* inc/hrs_pkg.sv */
// types shared by the return stack design
`include "hrs_regs.svh"

package hrs_pkg;

    typedef logic [`HRS_PTR_W-1:0] hrs_ptr_t;
    typedef logic [`HRS_IDX_W-1:0] hrs_idx_t;
    typedef logic [`HRS_WIDTH-1:0] hrs_entry_t;

    typedef enum logic [1:0]
    {
        HRS_OP_IDLE,
        HRS_OP_PUSH,
        HRS_OP_POP
    } hrs_op_e;

endpackage

/* hw/hrs_stack_mem.sv */
// sixteen entry flip-flop storage of the return stack, one write and one read port
`include "hrs_regs.svh"

module hrs_stack_mem
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              we,
    input  wire hrs_pkg::hrs_idx_t widx,
    input  wire hrs_pkg::hrs_entry_t wdata,
    input  wire hrs_pkg::hrs_idx_t ridx,
    output hrs_pkg::hrs_entry_t    rdata
);

    hrs_pkg::hrs_entry_t entry [`HRS_DEPTH];

    // storage lives apart from program and data space
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < `HRS_DEPTH; i++)
            begin
                entry[i] <= `HRS_ENTRY_RESET;
            end
        end
        else if (we)
        begin
            entry[widx] <= wdata;
        end
    end

    assign rdata = entry[ridx];

endmodule

/* hw/hrs_top.sv */
// hardware return stack with core push/pop port and apb register window
//
// What this block does
// - sixteen fifteen-bit entries, own storage space
// - push program counter on calls and vectoring
// - pop return address on any return
// - high latch register never touched
// - reset disabled: stack wraps circularly
// - fault flags set in both modes
// - top entry visible as high/low pair
// - pointer write repositions the top pair
// - pointer five bits, one spare value
// - push increments first, pop reads first
// - pointer marks most recently used entry
// - reset empties stack, pointer 0x1f
// - reset mode, empty: top pair reads zero
// - reset enabled: fault requests device reset
`include "hrs_regs.svh"

module hrs_top
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`HRS_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  push_req,
    input  wire hrs_pkg::hrs_entry_t   push_pc,
    input  wire logic                  pop_req,
    output hrs_pkg::hrs_entry_t        pop_pc,
    output logic                       pop_valid,
    output logic                       stack_reset_req,
    output logic                       irq
);

    // next pointer after a core operation, circular form
    function automatic hrs_pkg::hrs_ptr_t step_ptr(input hrs_pkg::hrs_op_e op, input hrs_pkg::hrs_ptr_t p);
        hrs_pkg::hrs_ptr_t r;
        r = p;
        case (op)
            hrs_pkg::HRS_OP_PUSH:
            begin
                if (p == `HRS_PTR_EMPTY)
                    r = `HRS_PTR_BOTTOM;
                else
                    r = {1'b0, p[3:0] + 4'h1};
            end
            hrs_pkg::HRS_OP_POP:
            begin
                if (p == `HRS_PTR_BOTTOM)
                    r = `HRS_PTR_EMPTY;
                else
                    r = {1'b0, p[3:0] - 4'h1};
            end
            default:
            begin
                r = p;
            end
        endcase
        return r;
    endfunction

    // overflow or underflow for this operation at this pointer
    function automatic logic is_fault(input hrs_pkg::hrs_op_e op, input hrs_pkg::hrs_ptr_t p);
        logic f;
        f = 1'b0;
        case (op)
            hrs_pkg::HRS_OP_PUSH:
            begin
                f = (p == `HRS_PTR_TOP) || (p[4] && (p != `HRS_PTR_EMPTY));
            end
            hrs_pkg::HRS_OP_POP:
            begin
                f = p[4];
            end
            default:
            begin
                f = 1'b0;
            end
        endcase
        return f;
    endfunction

    hrs_pkg::hrs_ptr_t             stack_pointer;
    logic                          stack_fault_reset_enable;
    logic [`HRS_STAT_W-1:0]        status;
    logic [`HRS_STAT_W-1:0]        mask;

    hrs_pkg::hrs_op_e              op;
    hrs_pkg::hrs_ptr_t             op_ptr;
    hrs_pkg::hrs_entry_t           top_entry;
    hrs_pkg::hrs_entry_t           tos_view;
    hrs_pkg::hrs_entry_t           merged;
    hrs_pkg::hrs_entry_t           mem_wdata;
    hrs_pkg::hrs_idx_t             mem_widx;
    logic                          mem_we;

    wire core_busy  = push_req | pop_req;
    wire apb_go     = psel & penable & ~pready & ~core_busy;
    wire sw_wr      = apb_go & pwrite;

    wire hit_top_of_stack_low   = paddr == `HRS_OFF_TOS_LOW;
    wire hit_top_of_stack_high   = paddr == `HRS_OFF_TOS_HIGH;
    wire hit_ptr    = paddr == `HRS_OFF_STACK_POINTER;
    wire hit_ctrl   = paddr == `HRS_OFF_CTRL;
    wire hit_stat   = paddr == `HRS_OFF_STATUS;
    wire hit_mask   = paddr == `HRS_OFF_MASK;
    wire addr_ok    = hit_top_of_stack_low | hit_top_of_stack_high | hit_ptr | hit_ctrl | hit_stat | hit_mask;

    // push wins if the core ever asks for both in one cycle
    assign op = push_req ? hrs_pkg::HRS_OP_PUSH :
                pop_req  ? hrs_pkg::HRS_OP_POP  : hrs_pkg::HRS_OP_IDLE;

    wire fault      = is_fault(op, stack_pointer);
    wire push_ovf   = (op == hrs_pkg::HRS_OP_PUSH) & fault;
    wire pop_unf    = (op == hrs_pkg::HRS_OP_POP) & fault;
    wire fault_rst  = fault & stack_fault_reset_enable;

    assign op_ptr = step_ptr(op, stack_pointer);

    // the read port always follows the pointer, so the pair tracks it
    hrs_stack_mem i_hrs_stack_mem
    (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (mem_we),
        .widx    (mem_widx),
        .wdata   (mem_wdata),
        .ridx    (stack_pointer[3:0]),
        .rdata   (top_entry)
    );

    // empty stack in reset mode hides stale contents
    assign tos_view = (stack_fault_reset_enable && stack_pointer == `HRS_PTR_EMPTY) ?
                      `HRS_ENTRY_RESET : top_entry;

    // byte writes keep the other half of the entry
    assign merged = hit_top_of_stack_low ? {top_entry[14:8], pwdata[7:0]} :
                               {pwdata[6:0], top_entry[7:0]};

    // push writes at the already advanced pointer; in circular mode wraps onto the oldest entry
    wire push_wr    = (op == hrs_pkg::HRS_OP_PUSH) & ~fault_rst;
    wire tos_wr     = sw_wr & (hit_top_of_stack_low | hit_top_of_stack_high);

    assign mem_we    = push_wr | tos_wr;
    assign mem_widx  = push_wr ? op_ptr[3:0] : stack_pointer[3:0];
    assign mem_wdata = push_wr ? push_pc : merged;

    wire [`HRS_STAT_W-1:0] stat_set;
    wire [`HRS_STAT_W-1:0] stat_clr;
    wire [`HRS_STAT_W-1:0] next_status;

    assign stat_set[`HRS_STAT_OVF_BIT] = push_ovf;
    assign stat_set[`HRS_STAT_UNF_BIT] = pop_unf;
    assign stat_clr    = (sw_wr & hit_stat) ? pwdata[`HRS_STAT_W-1:0] : `HRS_STATUS_RESET;
    // a fault in the clearing cycle is kept
    assign next_status = (status & ~stat_clr) | stat_set;

    wire [31:0] rd_mux =
        hit_top_of_stack_low ? {24'h000000, tos_view[7:0]} :
        hit_top_of_stack_high ? {25'h0, tos_view[14:8]} :
        hit_ptr  ? {27'h0, stack_pointer} :
        hit_ctrl ? {31'h0, stack_fault_reset_enable} :
        hit_stat ? {30'h0, status} :
        hit_mask ? {30'h0, mask} : 32'h00000000;

    // pointer: fault reset empties it, core moves it, software may place it
    hrs_pkg::hrs_ptr_t next_ptr;
    assign next_ptr = fault_rst               ? `HRS_PTR_EMPTY :
                      (op != hrs_pkg::HRS_OP_IDLE) ? op_ptr :
                      (sw_wr & hit_ptr)       ? pwdata[4:0] : stack_pointer;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stack_pointer <= `HRS_PTR_EMPTY;
        end
        else
        begin
            stack_pointer <= next_ptr;
        end
    end

    // register writes and reads decoded once, outside the flops
    wire ctrl_wr    = sw_wr & hit_ctrl;
    wire mask_wr    = sw_wr & hit_mask;
    wire rd_take    = apb_go & ~pwrite;
    wire pop_take   = op == hrs_pkg::HRS_OP_POP;
    wire next_irq   = |(next_status & mask);

    // in reset mode a faulting pop hands back zero, as the stack is being reset
    hrs_pkg::hrs_entry_t next_pop_pc;
    assign next_pop_pc = fault_rst ? `HRS_ENTRY_RESET : top_entry;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stack_fault_reset_enable <= `HRS_CTRL_RESET;
        end
        else if (ctrl_wr)
        begin
            stack_fault_reset_enable <= pwdata[`HRS_CTRL_FAULT_RST_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask <= `HRS_MASK_RESET;
        end
        else if (mask_wr)
        begin
            mask <= pwdata[`HRS_STAT_W-1:0];
        end
    end

    // flags survive the stack reset they trigger; presetn or a one written to status clears them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status <= `HRS_STATUS_RESET;
        end
        else
        begin
            status <= next_status;
        end
    end

    // irq updates on the same edge as status but stays a clean flop output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= next_irq;
        end
    end

    // core answer strobes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pop_valid       <= 1'b0;
            stack_reset_req <= 1'b0;
        end
        else
        begin
            pop_valid       <= pop_take;
            stack_reset_req <= fault_rst;
        end
    end

    // popped address is read before the pointer moves; held until the next pop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pop_pc <= `HRS_ENTRY_RESET;
        end
        else if (pop_take)
        begin
            pop_pc <= next_pop_pc;
        end
    end

    // apb: one wait state, stretched while the core owns the stack
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= apb_go;
            pslverr <= apb_go & ~addr_ok;
        end
    end

    // read data held until the next read so a slow master still sees it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
        end
        else if (rd_take)
        begin
            prdata <= rd_mux;
        end
    end

    // nothing here drives the high latch register
    // a pointer write racing a core push is delayed, not merged

endmodule

/* bench/hrs_props.sv */
// port timing checker of the return stack
module hrs_props
(
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic                push_req,
    input wire logic                pop_req,
    input wire hrs_pkg::hrs_entry_t pop_pc,
    input wire logic                pop_valid,
    input wire logic                stack_reset_req
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_pop; pop_req && !push_req; endsequence
    sequence s_wait; psel && penable && !pready && !push_req && !pop_req; endsequence
    a_pop_answer: assert property (s_pop |=> pop_valid)
        else $error("pop not answered");
    a_pop_cause: assert property (pop_valid |-> $past(pop_req && !push_req))
        else $error("pop answer without pop");
    a_pop_hold: assert property (!$past(pop_req && !push_req) |-> $stable(pop_pc))
        else $error("popped value moved");
    a_apb_answer: assert property (s_wait |=> pready)
        else $error("access not answered");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready outside access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_core_first: assert property (pready |-> $past(!push_req && !pop_req))
        else $error("register access beside core request");
    a_fault_pulse: assert property (stack_reset_req |-> $past(push_req || pop_req) ##1 !stack_reset_req)
        else $error("reset request not a pulse after core op");
endmodule

bind hrs_top hrs_props i_hrs_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .push_req, .pop_req, .pop_pc, .pop_valid, .stack_reset_req);

/* bench/hrs_core_model.sv */
// core sequencer model issuing push and pop pulses
module hrs_core_model
(
    input  wire logic          pclk,
    output logic               push_req,
    output hrs_pkg::hrs_entry_t push_pc,
    output logic               pop_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        push_req = 1'b0;
        push_pc = 15'h0000;
        pop_req = 1'b0;
    end
    // value inverted after use so a late sample is caught
    task automatic push(input hrs_pkg::hrs_entry_t pc);
        push_req <= 1'b1;
        push_pc <= pc;
        @(posedge pclk);
        push_req <= 1'b0;
        push_pc <= ~pc;
        @(posedge pclk);
    endtask
    task automatic pop();
        pop_req <= 1'b1;
        @(posedge pclk);
        pop_req <= 1'b0;
        @(posedge pclk);
    endtask
    // both requests at once: the push must win and the pop be dropped
    task automatic push_pop(input hrs_pkg::hrs_entry_t pc);
        push_req <= 1'b1;
        pop_req <= 1'b1;
        push_pc <= pc;
        @(posedge pclk);
        push_req <= 1'b0;
        pop_req <= 1'b0;
        push_pc <= ~pc;
        @(posedge pclk);
    endtask
endmodule

/* bench/hrs_top_tb.sv */
// self-checking bench of the return stack
`include "hrs_regs.svh"

module hrs_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic               push_req, pop_req, pop_valid, stack_reset_req, irq;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata;
    hrs_pkg::hrs_entry_t push_pc, pop_pc, v;
    hrs_pkg::hrs_entry_t mem[16];
    logic [32:0]        exp_q[$];
    logic [4:0]         sp;
    int                 miscompares = 0;
    int                 checked = 0;
    int                 faults = 0;
    int                 cycles = 0;

    hrs_top i_hrs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .push_req, .push_pc, .pop_req, .pop_pc, .pop_valid, .stack_reset_req, .irq);
    hrs_core_model i_hrs_core_model (.pclk, .push_req, .push_pc, .pop_req);

    task automatic print_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [32:0] got, input logic [32:0] want);
        checked++;
        if (got !== want)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        if (!w)
            exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rtos();
        rd(`HRS_OFF_TOS_LOW, {24'h0, mem[sp[3:0]][7:0]});
        rd(`HRS_OFF_TOS_HIGH, {25'h0, mem[sp[3:0]][14:8]});
        rd(`HRS_OFF_STACK_POINTER, {27'h0, sp});
    endtask
    // reference keeps circular mode only
    task automatic push_v(input hrs_pkg::hrs_entry_t x);
        sp = {1'b0, sp[3:0] + 4'h1};
        mem[sp[3:0]] = x;
        i_hrs_core_model.push(x);
    endtask
    task automatic pop_e();
        exp_q.push_back({18'h0, mem[sp[3:0]]});
        sp = (sp == 5'h00) ? 5'h1f : {1'b0, sp[3:0] - 4'h1};
        i_hrs_core_model.pop();
    endtask
    task automatic chk_irq(input logic e);
        @(negedge pclk);
        cmp({32'h0, irq}, {32'h0, e});
        @(posedge pclk);
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (stack_reset_req === 1'b1)
            faults++;
        if (pop_valid === 1'b1 || (pready === 1'b1 && psel === 1'b1 && pwrite === 1'b0))
            cmp((pop_valid === 1'b1) ? {18'h0, pop_pc} : {pslverr, prdata}, exp_q.pop_front());
        if (cycles == 5000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        sp = `HRS_PTR_EMPTY;
        foreach (mem[i]) mem[i] = `HRS_ENTRY_RESET;
        void'($urandom(98));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rtos();
        rd(`HRS_OFF_CTRL, 32'h0);
        rd(`HRS_OFF_STATUS, 32'h0);
        apb(1'b0, 12'h018, 32'h0, {1'b1, 32'h0});
        $display("test 1 done");
        repeat (16)
        begin
            push_v(15'($urandom));
            rtos();
        end
        repeat (16)
        begin
            pop_e();
            rtos();
        end
        rd(`HRS_OFF_STATUS, 32'h0);
        $display("test 2 done");
        repeat (17) push_v(15'($urandom));
        rtos();
        rd(`HRS_OFF_STATUS, 32'h1);
        wr(`HRS_OFF_MASK, 32'h3);
        chk_irq(1'b1);
        wr(`HRS_OFF_STATUS, 32'h1);
        chk_irq(1'b0);
        sp = `HRS_PTR_EMPTY;
        wr(`HRS_OFF_STACK_POINTER, 32'h1f);
        pop_e();
        rd(`HRS_OFF_STATUS, 32'h2);
        rtos();
        wr(`HRS_OFF_STATUS, 32'h3);
        $display("test 3 done");
        v = 15'($urandom);
        sp = 5'h05;
        mem[5] = v;
        wr(`HRS_OFF_STACK_POINTER, 32'h5);
        wr(`HRS_OFF_TOS_LOW, {24'h0, v[7:0]});
        wr(`HRS_OFF_TOS_HIGH, {25'h0, v[14:8]});
        rtos();
        pop_e();
        rtos();
        v = 15'($urandom);
        sp = 5'h05;
        mem[5] = v;
        i_hrs_core_model.push_pop(v);
        rtos();
        fork
            rd(`HRS_OFF_STACK_POINTER, 32'h6);
            begin
                @(posedge pclk);
                push_v(15'($urandom));
            end
        join
        rtos();
        $display("test 4 done");
        wr(`HRS_OFF_CTRL, 32'h1);
        wr(`HRS_OFF_STACK_POINTER, 32'h1f);
        rd(`HRS_OFF_TOS_LOW, 32'h0);
        rd(`HRS_OFF_TOS_HIGH, 32'h0);
        exp_q.push_back(33'h0);
        i_hrs_core_model.pop();
        wr(`HRS_OFF_STACK_POINTER, 32'hf);
        i_hrs_core_model.push(v);
        @(posedge pclk);
        cmp(33'(faults), 33'h2);
        rd(`HRS_OFF_STATUS, 32'h3);
        rd(`HRS_OFF_STACK_POINTER, 32'h1f);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        sp = `HRS_PTR_EMPTY;
        foreach (mem[i]) mem[i] = `HRS_ENTRY_RESET;
        rtos();
        rd(`HRS_OFF_CTRL, 32'h0);
        chk_irq(1'b0);
        $display("test 5 done");
        print_verdict();
    end
endmodule
